// ==== logic/trib_pkg.sv ====
// shared constants, field layouts and carrier types of the tributary block
package trib_pkg;
   // frame geometry of the byte-interleaved stm-1 stream
   localparam int unsigned    SETS       = 3;
   localparam logic [3:0]     ROW_LAST   = 4'h8;
   localparam logic [8:0]     COL_LAST   = 9'h10D;
   localparam logic [8:0]     TOH_COLS   = 9'h009;
   localparam logic [8:0]     AU4_POH    = 9'h009;
   localparam logic [8:0]     TUG3_FIRST = 9'h00C;
   localparam logic [3:0]     H4_ROW     = 4'h5;
   localparam logic [3:0]     PTR_ROW    = 4'h3;
   localparam logic [6:0]     STUFF_A    = 7'h1D;
   localparam logic [6:0]     STUFF_B    = 7'h3A;
   localparam logic [8:0]     H4_DIST    = 9'h1C2;
   // register offsets and reset values
   localparam logic [7:0]     OFF_CTRL   = 8'h00;
   localparam logic [7:0]     OFF_GRP0   = 8'h04;
   localparam logic [7:0]     OFF_GRP1   = 8'h08;
   localparam logic [7:0]     OFF_GRP2   = 8'h0C;
   localparam logic [7:0]     OFF_STAT   = 8'h10;
   localparam logic [7:0]     OFF_PERR   = 8'h14;
   localparam logic [8:0]     CTRL_RST   = 9'h000;
   localparam logic [13:0]    GRP_RST    = 14'h0000;
   // fixed overhead byte values
   localparam logic [9:0]     AU_OFFSET  = 10'h20A;
   localparam logic [7:0]     A1_VAL     = 8'hF6;
   localparam logic [7:0]     A2_VAL     = 8'h28;
   localparam logic [7:0]     PTR_H1     = {6'h18, AU_OFFSET[9:8]};
   localparam logic [7:0]     PTR_H2     = AU_OFFSET[7:0];
   localparam logic [7:0]     CI_H1      = 8'h93;
   localparam logic [7:0]     CI_H2      = 8'hFF;
   localparam logic [7:0]     NPI_H1     = 8'h93;
   localparam logic [7:0]     NPI_H2     = 8'hE0;
   localparam logic [7:0]     TU3_H1     = 8'h60;
   localparam logic [7:0]     TU3_H2     = 8'h00;
   localparam logic [7:0]     H4_ONES    = 8'hFC;
   // classes of an outgoing byte slot
   typedef enum logic [3:0] {
      CL_A1, CL_A2, CL_H1, CL_H2, CL_TOH0, CL_J1, CL_POH0, CL_H4,
      CL_STUFF, CL_TUPH1, CL_TUPH2, CL_TUPH3, CL_PAY
   } slot_cls_t;
   typedef enum logic [1:0] {GT_VT15, GT_VT2, GT_VT3, GT_VT6} grp_type_t;
   typedef enum logic [1:0] {AL_HUNT, AL_COUNT, AL_LOCK} align_st_t;
   typedef struct packed {
      logic [2:0] tu3;
      logic [2:0] tug3;
      logic       mfctl;
      logic       ocat;
      logic       icat;
   } cfg_t;
   typedef struct packed {
      slot_cls_t  cls;
      logic [1:0] set;
      logic [6:0] scol;
      logic [2:0] grp;
   } slot_t;
endpackage : trib_pkg

// ==== logic/slot_mapper.sv ====
// classifies one outgoing byte slot from its row and column
module slot_mapper (
   // position and mode
   input  wire logic [3:0]      row,
   input  wire logic [8:0]      col,
   input  wire logic            au4,
   input  wire logic [2:0]      tug3,
   // classification
   output trib_pkg::slot_t      slot
);
   logic [8:0] k;
   logic [6:0] a;
   logic [6:0] n;

   // toh, poh, fixed stuff or payload; group index counts payload columns
   always_comb begin
      slot = '{cls: trib_pkg::CL_TOH0, set: 2'h0, scol: 7'h00, grp: 3'h0};
      k = 9'h000;
      a = 7'h00;
      n = 7'h00;
      if (col < trib_pkg::TOH_COLS) begin
         slot.set = 2'(col % 9'h003);
         if (row == 4'h0 && col < 9'h003) slot.cls = trib_pkg::CL_A1;
         else if (row == 4'h0 && col < 9'h006) slot.cls = trib_pkg::CL_A2;
         else if (row == trib_pkg::PTR_ROW && col < 9'h003)
            slot.cls = trib_pkg::CL_H1;
         else if (row == trib_pkg::PTR_ROW && col < 9'h006)
            slot.cls = trib_pkg::CL_H2;
      end else if (!au4) begin
         k = col - trib_pkg::TOH_COLS;
         slot.set = 2'(k % 9'h003);
         a = 7'(k / 9'h003);
         if (a == 7'h00) begin
            slot.cls = (row == 4'h0) ? trib_pkg::CL_J1 :
                       (row == trib_pkg::H4_ROW) ? trib_pkg::CL_H4 :
                       trib_pkg::CL_POH0;
         end else if (a == trib_pkg::STUFF_A || a == trib_pkg::STUFF_B) begin
            slot.cls = trib_pkg::CL_STUFF;
         end else begin
            slot.cls = trib_pkg::CL_PAY;
            slot.scol = a;
            n = a - 7'h01 - ((a > trib_pkg::STUFF_A) ? 7'h01 : 7'h00)
                - ((a > trib_pkg::STUFF_B) ? 7'h01 : 7'h00);
            slot.grp = 3'(n % 7'h07);
         end
      end else if (col == trib_pkg::AU4_POH) begin
         slot.cls = (row == 4'h0) ? trib_pkg::CL_J1 :
                    (row == trib_pkg::H4_ROW) ? trib_pkg::CL_H4 :
                    trib_pkg::CL_POH0;
      end else if (col < trib_pkg::TUG3_FIRST) begin
         slot.cls = trib_pkg::CL_STUFF;
      end else begin
         k = col - trib_pkg::TUG3_FIRST;
         slot.set = 2'(k % 9'h003);
         a = 7'(k / 9'h003);
         if (a == 7'h00) begin
            slot.cls = (row == 4'h0) ? trib_pkg::CL_TUPH1 :
                       (row == 4'h1) ? trib_pkg::CL_TUPH2 :
                       (row == 4'h2) ? trib_pkg::CL_TUPH3 :
                       trib_pkg::CL_STUFF;
         end else if (a == 7'h01 && tug3[slot.set]) begin
            slot.cls = trib_pkg::CL_STUFF;
         end else begin
            slot.cls = trib_pkg::CL_PAY;
            slot.scol = a;
            n = a - 7'h02;
            slot.grp = 3'(n % 7'h07);
         end
      end
   end
endmodule : slot_mapper

// ==== logic/mf_aligner.sv ====
// per-set tributary multiframe alignment taken from the set's own h4 byte
module mf_aligner (
   // clock and reset
   input  wire logic            clk,
   input  wire logic            rst,
   // lane byte stream
   input  wire logic            lane_en,
   input  wire logic            marker,
   input  wire logic [7:0]      data,
   input  wire logic            enable,
   // alignment result
   output logic [1:0]           phase,
   output logic                 locked
);
   trib_pkg::align_st_t st_reg;
   logic [8:0]          cnt_reg;

   // h4 sits five rows below j1, i.e. a fixed count of lane bytes later
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg  <= trib_pkg::AL_HUNT;
         cnt_reg <= 9'h000;
         phase   <= 2'h0;
         locked  <= 1'b0;
      end else if (!enable) begin
         st_reg  <= trib_pkg::AL_HUNT;
         locked  <= 1'b0;
      end else if (lane_en) begin
         case (st_reg)
            trib_pkg::AL_HUNT, trib_pkg::AL_LOCK: begin
               if (marker) begin
                  st_reg  <= trib_pkg::AL_COUNT;
                  cnt_reg <= 9'h001;
               end
            end
            trib_pkg::AL_COUNT: begin
               if (cnt_reg == trib_pkg::H4_DIST) begin
                  st_reg <= trib_pkg::AL_LOCK;
                  phase  <= data[1:0];
                  // a skipped phase means the sequence is broken
                  locked <= (phase + 2'h1 == data[1:0]);
               end else begin
                  cnt_reg <= cnt_reg + 9'h001;
               end
            end
            default: st_reg <= trib_pkg::AL_HUNT;
         endcase
      end
   end
endmodule : mf_aligner

// ==== logic/trib_coord.sv ====
// mode coordination and outgoing frame builder of one stm-1 tributary unit
//
// Added by the designer: the placing of the registers and register access over APB.
module trib_coord (
   // clock and reset
   input  wire logic            SYS_CLK,
   input  wire logic            RST,
   // apb slave
   input  wire logic            PSEL,
   input  wire logic            PENABLE,
   input  wire logic            PWRITE,
   input  wire logic [7:0]      PADDR,
   input  wire logic [31:0]     PWDATA,
   output logic [31:0]          PRDATA,
   output logic                 PREADY,
   output logic                 PSLVERR,
   // incoming data bus
   input  wire logic [7:0]      IN_DATA,
   input  wire logic            IN_PAR,
   input  wire logic            IN_MARKER,
   // per-set markers and multiframe phase
   output logic [2:0]           SET_MARKER,
   output logic [5:0]           SET_MF_PHASE,
   // payload source
   input  wire logic [7:0]      PAY_DATA,
   output logic                 PAY_TAKE,
   output logic [1:0]           PAY_SET,
   output logic [6:0]           PAY_COL,
   output logic [2:0]           PAY_GROUP,
   output logic [1:0]           PAY_GTYPE,
   output logic                 PAY_TU3,
   // outgoing data bus
   output logic [7:0]           OUT_DATA,
   output logic                 OUT_PAR,
   output logic                 OUT_J1
);
   trib_pkg::cfg_t      cfg_reg;
   logic [13:0]         grp_reg [trib_pkg::SETS];
   logic [15:0]         perr_reg;
   logic                au4_reg;
   logic [2:0]          tug3m_reg;
   logic [2:0]          tu3m_reg;
   logic                cfgerr_reg;
   logic [1:0]          lane_reg;
   logic [1:0]          stretch_reg;
   logic                mark_d_reg;
   logic [3:0]          row_reg;
   logic [8:0]          col_reg;
   logic [1:0]          mfcnt_reg;
   trib_pkg::slot_cls_t out_cls_reg;
   logic [1:0]          out_set_reg;
   logic [1:0]          cur_lane;
   logic [2:0]          mk;
   logic [1:0]          ph [trib_pkg::SETS];
   logic [2:0]          lk;
   logic [7:0]          gen_byte;
   logic                access;
   logic                wr_done;
   logic                hit;
   logic [31:0]         rd_mux;
   trib_pkg::slot_t     slot;

   ////////////////////////////////////////////////////////////////////////
   // apb register access
   assign access  = PSEL && PENABLE;
   assign wr_done = access && PREADY && PWRITE;
   assign hit     = PADDR == trib_pkg::OFF_CTRL ||
                    PADDR == trib_pkg::OFF_GRP0 ||
                    PADDR == trib_pkg::OFF_GRP1 ||
                    PADDR == trib_pkg::OFF_GRP2 ||
                    PADDR == trib_pkg::OFF_STAT ||
                    PADDR == trib_pkg::OFF_PERR;

   // read data mux; reserved bits read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (PADDR)
         trib_pkg::OFF_CTRL: rd_mux = {23'h00_0000, cfg_reg};
         trib_pkg::OFF_GRP0: rd_mux = {18'h0_0000, grp_reg[0]};
         trib_pkg::OFF_GRP1: rd_mux = {18'h0_0000, grp_reg[1]};
         trib_pkg::OFF_GRP2: rd_mux = {18'h0_0000, grp_reg[2]};
         trib_pkg::OFF_STAT: rd_mux = {13'h0000, lk, SET_MF_PHASE,
                                       mfcnt_reg, cfgerr_reg, tu3m_reg,
                                       tug3m_reg, au4_reg};
         trib_pkg::OFF_PERR: rd_mux = {16'h0000, perr_reg};
         default:            rd_mux = 32'h0000_0000;
      endcase
   end

   // one wait state: answer on the second access cycle
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0000_0000;
      end else begin
         PREADY  <= access && !PREADY;
         PSLVERR <= access && !PREADY && !hit;
         PRDATA  <= (access && !PREADY && !PWRITE) ? rd_mux : 32'h0000_0000;
      end
   end

   // configuration registers, written on the completing edge only
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         cfg_reg    <= trib_pkg::CTRL_RST;
         grp_reg[0] <= trib_pkg::GRP_RST;
         grp_reg[1] <= trib_pkg::GRP_RST;
         grp_reg[2] <= trib_pkg::GRP_RST;
      end else if (wr_done) begin
         case (PADDR)
            trib_pkg::OFF_CTRL: cfg_reg    <= PWDATA[8:0];
            trib_pkg::OFF_GRP0: grp_reg[0] <= PWDATA[13:0];
            trib_pkg::OFF_GRP1: grp_reg[1] <= PWDATA[13:0];
            trib_pkg::OFF_GRP2: grp_reg[2] <= PWDATA[13:0];
            default: ;
         endcase
      end
   end

   // incoming parity error count; a new error beats the clearing write
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         perr_reg <= 16'h0000;
      end else if (IN_PAR != ^IN_DATA) begin
         if (wr_done && PADDR == trib_pkg::OFF_PERR) perr_reg <= 16'h0001;
         else if (perr_reg != 16'hFFFF) perr_reg <= perr_reg + 16'h0001;
      end else if (wr_done && PADDR == trib_pkg::OFF_PERR) begin
         perr_reg <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode decode
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         au4_reg    <= 1'b0;
         tug3m_reg  <= 3'h0;
         tu3m_reg   <= 3'h0;
         cfgerr_reg <= 1'b0;
      end else begin
         au4_reg    <= cfg_reg.icat && cfg_reg.ocat;
         tug3m_reg  <= (cfg_reg.icat && cfg_reg.ocat) ?
                       cfg_reg.tug3 : 3'h0;
         tu3m_reg   <= (cfg_reg.icat && cfg_reg.ocat) ?
                       (cfg_reg.tu3 & ~cfg_reg.tug3) : 3'h0;
         // each set in au4 needs exactly one of tug3 or tu3
         cfgerr_reg <= cfg_reg.icat && cfg_reg.ocat &&
                       ((cfg_reg.tug3 ~^ cfg_reg.tu3) != 3'h0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // input demultiplexer: lane follows the marker's rising edge
   assign cur_lane = (IN_MARKER && !mark_d_reg) ? 2'h0 : lane_reg;

   // per-lane markers; in au4 one marker covers three lanes
   always_comb begin
      for (int s = 0; s < trib_pkg::SETS; s++) begin
         mk[s] = (cur_lane == 2'(s)) &&
                 (IN_MARKER || (au4_reg && stretch_reg != 2'h0));
      end
   end

   // lane counter and marker stretch
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         lane_reg    <= 2'h0;
         stretch_reg <= 2'h0;
         mark_d_reg  <= 1'b0;
      end else begin
         lane_reg    <= (cur_lane == 2'h2) ? 2'h0 : cur_lane + 2'h1;
         mark_d_reg  <= IN_MARKER;
         if (au4_reg && IN_MARKER && !mark_d_reg)
            stretch_reg <= 2'h2;
         else if (stretch_reg != 2'h0)
            stretch_reg <= stretch_reg - 2'h1;
      end
   end

   // one aligner per set; h4 framing only while the control is zero
   for (genvar s = 0; s < trib_pkg::SETS; s++) begin : g_set
      mf_aligner u_align (
         .clk     (SYS_CLK),
         .rst     (RST),
         .lane_en (cur_lane == 2'(s)),
         .marker  (mk[s]),
         .data    (IN_DATA),
         .enable  (!cfg_reg.mfctl),
         .phase   (ph[s]),
         .locked  (lk[s])
      );
   end

   // slaved sets share set one's phase when concatenated
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         SET_MARKER   <= 3'h0;
         SET_MF_PHASE <= 6'h00;
      end else begin
         SET_MARKER   <= mk;
         SET_MF_PHASE <= au4_reg ? {ph[0], ph[0], ph[0]} :
                         {ph[2], ph[1], ph[0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outgoing frame position and multiframe count
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         row_reg   <= 4'h0;
         col_reg   <= 9'h000;
         mfcnt_reg <= 2'h0;
      end else if (col_reg != trib_pkg::COL_LAST) begin
         col_reg <= col_reg + 9'h001;
      end else begin
         col_reg <= 9'h000;
         if (row_reg == trib_pkg::ROW_LAST) begin
            row_reg   <= 4'h0;
            mfcnt_reg <= mfcnt_reg + 2'h1;
         end else begin
            row_reg <= row_reg + 4'h1;
         end
      end
   end

   // slot classification; column sets follow from the au3 interleave
   slot_mapper u_map (
      .row  (row_reg),
      .col  (col_reg),
      .au4  (au4_reg),
      .tug3 (tug3m_reg),
      .slot (slot)
   );

   // generated byte for every non-payload slot
   always_comb begin
      case (slot.cls)
         trib_pkg::CL_A1:    gen_byte = trib_pkg::A1_VAL;
         trib_pkg::CL_A2:    gen_byte = trib_pkg::A2_VAL;
         trib_pkg::CL_H1:    gen_byte = (au4_reg && slot.set != 2'h0) ?
                                        trib_pkg::CI_H1 :
                                        trib_pkg::PTR_H1;
         trib_pkg::CL_H2:    gen_byte = (au4_reg && slot.set != 2'h0) ?
                                        trib_pkg::CI_H2 :
                                        trib_pkg::PTR_H2;
         trib_pkg::CL_H4:    gen_byte = trib_pkg::H4_ONES |
                                        {6'h00, mfcnt_reg};
         trib_pkg::CL_TUPH1: gen_byte = tu3m_reg[slot.set] ?
                                        trib_pkg::TU3_H1 :
                                        trib_pkg::NPI_H1;
         trib_pkg::CL_TUPH2: gen_byte = tu3m_reg[slot.set] ?
                                        trib_pkg::TU3_H2 :
                                        trib_pkg::NPI_H2;
         trib_pkg::CL_PAY:   gen_byte = PAY_DATA;
         default:            gen_byte = 8'h00;
      endcase
   end

   // outgoing byte, parity and payload request, all from one edge
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         OUT_DATA    <= 8'h00;
         OUT_PAR     <= 1'b0;
         OUT_J1      <= 1'b0;
         out_cls_reg <= trib_pkg::CL_TOH0;
         out_set_reg <= 2'h0;
      end else begin
         OUT_DATA    <= gen_byte;
         OUT_PAR     <= ^gen_byte;
         OUT_J1      <= slot.cls == trib_pkg::CL_J1;
         out_cls_reg <= slot.cls;
         out_set_reg <= slot.set;
      end
   end

   // payload slot description for the tributary source
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         PAY_TAKE  <= 1'b0;
         PAY_SET   <= 2'h0;
         PAY_COL   <= 7'h00;
         PAY_GROUP <= 3'h0;
         PAY_GTYPE <= 2'h0;
         PAY_TU3   <= 1'b0;
      end else begin
         PAY_TAKE  <= slot.cls == trib_pkg::CL_PAY;
         PAY_SET   <= slot.set;
         PAY_COL   <= slot.scol;
         PAY_TU3   <= tu3m_reg[slot.set];
         PAY_GROUP <= tu3m_reg[slot.set] ? 3'h0 : slot.grp;
         PAY_GTYPE <= tu3m_reg[slot.set] ? 2'h0 :
                      grp_reg[slot.set][{slot.grp, 1'b0} +: 2];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   out_parity_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      OUT_PAR == ^OUT_DATA) else $error("outgoing parity mismatch");
   au4_gate_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      au4_reg |-> $past(cfg_reg.icat) && $past(cfg_reg.ocat))
      else $error("au4 without both concat bits");
   marker_stretch_a: assert property (@(posedge SYS_CLK)
      disable iff (RST)
      (au4_reg && IN_MARKER && !mark_d_reg) ##1 au4_reg
      |-> mk == 3'h2 ##1 mk == 3'h4)
      else $error("concatenated marker not stretched");
   mf_share_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      au4_reg && $past(au4_reg) |-> SET_MF_PHASE[5:4] == SET_MF_PHASE[1:0]
      && SET_MF_PHASE[3:2] == SET_MF_PHASE[1:0])
      else $error("slaved set phase differs");
   h4_byte_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      out_cls_reg == trib_pkg::CL_H4 |-> OUT_DATA[7:2] == 6'h3F
      && OUT_DATA[1:0] == mfcnt_reg) else $error("bad outgoing h4");
   zero_fill_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      out_cls_reg inside {trib_pkg::CL_STUFF, trib_pkg::CL_TOH0,
      trib_pkg::CL_POH0} |-> OUT_DATA == 8'h00)
      else $error("stuff or overhead byte not zero");
   au_pointer_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      out_cls_reg == trib_pkg::CL_H1 && out_set_reg == 2'h0
      |-> OUT_DATA == 8'h62 ##1 OUT_DATA == ($past(au4_reg) ? 8'h93 : 8'h62)
      ##2 OUT_DATA == 8'h0A)
      else $error("pointer not at 522");
   tu_null_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      out_cls_reg == trib_pkg::CL_TUPH1 && tug3m_reg[out_set_reg]
      |-> OUT_DATA == 8'h93) else $error("null pointer missing");
   mf_step_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      row_reg == 4'h8 && col_reg == 9'h10D
      |=> mfcnt_reg == $past(mfcnt_reg) + 2'h1)
      else $error("multiframe count did not step");
   first_tu_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      !au4_reg && col_reg == 9'h00C && row_reg != 4'h0 |=> PAY_TAKE
      && PAY_COL == 7'h01 && PAY_GROUP == 3'h0 && PAY_SET == 2'h0)
      else $error("first tributary column misplaced");
   apb_answer_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("apb answer late");

   au4_frame_c: cover property (@(posedge SYS_CLK) disable iff (RST)
      au4_reg && OUT_J1);
   lock_c: cover property (@(posedge SYS_CLK) disable iff (RST)
      lk == 3'h7);
   perr_c: cover property (@(posedge SYS_CLK) disable iff (RST)
      wr_done && PADDR == trib_pkg::OFF_PERR && IN_PAR != ^IN_DATA);
endmodule : trib_coord

// ==== tb/upstream_src.sv ====
// upstream byte source and payload feeder for the tributary unit
module upstream_src (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // marker request, length in bytes
   input  wire logic [1:0] mark_len,
   // incoming bus and payload
   output logic [7:0]      data,
   output logic            par,
   output logic            marker,
   output logic [7:0]      pay
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] left_reg;
   ////////////////////////////////////////////////////////////////////////
   // counting bytes; overhead content is a don't-care upstream
   always_ff @(posedge clk or posedge rst) begin
      if (rst) data <= 8'h00;
      else data <= data + 8'h01;
   end
   // marker held over the j1 byte or bytes only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) left_reg <= 2'h0;
      else if (mark_len != 2'h0) left_reg <= mark_len;
      else if (left_reg != 2'h0) left_reg <= left_reg - 2'h1;
   end
   assign marker = (left_reg != 2'h0);
   assign par    = ^data;
   // inverted so a swap of the two byte paths shows up
   assign pay    = ~data;
endmodule : upstream_src

// ==== tb/testbench.sv ====
// self-checking bench: apb modes, marker split, outgoing frame bytes
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        SYS_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic [7:0]  PADDR, IN_DATA, PAY_DATA, OUT_DATA, pay_d;
   logic [31:0] PWDATA, PRDATA, rd;
   logic        IN_PAR, IN_MARKER, PAY_TAKE, PAY_TU3, OUT_PAR, OUT_J1;
   logic [2:0]  SET_MARKER, PAY_GROUP;
   logic [5:0]  SET_MF_PHASE;
   logic [1:0]  PAY_SET, PAY_GTYPE, mark_len, mf_prev;
   logic [6:0]  PAY_COL;
   logic        perr, au4, mixed;
   logic        have = 1'b0;
   int          err_count, compares, pos;
   ////////////////////////////////////////////////////////////////////////
   trib_coord trib_coord_i (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .IN_DATA(IN_DATA), .IN_PAR(IN_PAR), .IN_MARKER(IN_MARKER),
      .SET_MARKER(SET_MARKER), .SET_MF_PHASE(SET_MF_PHASE),
      .PAY_DATA(PAY_DATA), .PAY_TAKE(PAY_TAKE), .PAY_SET(PAY_SET),
      .PAY_COL(PAY_COL), .PAY_GROUP(PAY_GROUP), .PAY_GTYPE(PAY_GTYPE),
      .PAY_TU3(PAY_TU3), .OUT_DATA(OUT_DATA), .OUT_PAR(OUT_PAR),
      .OUT_J1(OUT_J1));
   upstream_src upstream_src_i (.clk(SYS_CLK), .rst(RST),
      .mark_len(mark_len), .data(IN_DATA), .par(IN_PAR),
      .marker(IN_MARKER), .pay(PAY_DATA));
   ////////////////////////////////////////////////////////////////////////
   // 200 MHz clock
   always #2.5 SYS_CLK = ~SYS_CLK;
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic results;
      $display("mismatches %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   // one apb transfer; waits on pready with a bound
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge SYS_CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 50);
      rd = PRDATA;
      perr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge SYS_CLK);
      if (n >= 50) begin
         err_count++;
         results;
      end
   endtask : apb
   // one marker of len bytes; expect one set per byte in turn
   task automatic mark(input logic [1:0] len);
      mark_len <= len;
      @(posedge SYS_CLK);
      mark_len <= 2'h0;
      for (int i = 0; i < 3; i++) begin
         @(posedge SYS_CLK);
         @(negedge SYS_CLK);
         chk("set marker", SET_MARKER, 3'h1 << i);
      end
      @(posedge SYS_CLK);
   endtask : mark
   ////////////////////////////////////////////////////////////////////////
   // byte position of what the outgoing bus shows now
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) pos <= -1;
      else pos <= (pos == 2429) ? 0 : pos + 1;
   end
   // payload byte the design took at this edge
   always @(posedge SYS_CLK) pay_d <= PAY_DATA;
   // outgoing frame watcher; settled values read mid-cycle
   always @(negedge SYS_CLK) if (!RST && pos >= 0) begin
      chk("out parity", OUT_PAR, ^OUT_DATA);
      if (PAY_TAKE) chk("payload", OUT_DATA, pay_d);
      case (pos)
         0: chk("a1", OUT_DATA, trib_pkg::A1_VAL);
         3: chk("a2", OUT_DATA, trib_pkg::A2_VAL);
         9: chk("j1", {OUT_J1, OUT_DATA}, 9'h100);
         12: if (mixed) begin
            chk("tu3 h1", OUT_DATA, trib_pkg::TU3_H1);
            chk("tu3 flag", PAY_TU3, 1'b1);
         end else begin
            chk("first tu", {PAY_TAKE, PAY_SET, PAY_COL, PAY_GROUP,
                PAY_GTYPE}, 15'h4020);
         end
         13: if (mixed) chk("npi h1", OUT_DATA, trib_pkg::NPI_H1);
         269: if (!au4) chk("last tu", {PAY_TAKE, PAY_SET, PAY_COL,
                  PAY_GROUP, PAY_GTYPE}, 15'h6ADA);
         271: chk("toh zero", OUT_DATA, 32'h0000_0000);
         810: chk("h1", OUT_DATA, trib_pkg::PTR_H1);
         811: chk("h1 b", OUT_DATA,
                  au4 ? trib_pkg::CI_H1 : trib_pkg::PTR_H1);
         813: chk("h2", OUT_DATA, trib_pkg::PTR_H2);
         1359: begin
            chk("h4 ones", OUT_DATA[7:2], trib_pkg::H4_ONES[7:2]);
            if (have) chk("h4 cnt", OUT_DATA[1:0], 2'(mf_prev + 2'h1));
            mf_prev = OUT_DATA[1:0];
            have = 1'b1;
         end
         1360: chk("h4 b", OUT_DATA, au4 ? 8'h00 : {6'h3F, mf_prev});
         default: ;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      SYS_CLK = 1'b0; RST = 1'b1; PSEL = 1'b0; PENABLE = 1'b0;
      PWRITE = 1'b0; PADDR = 8'h00; PWDATA = 32'h0000_0000;
      mark_len = 2'h0; au4 = 1'b0; mixed = 1'b0;
      err_count = 0; compares = 0;
      repeat (4) @(posedge SYS_CLK);
      RST <= 1'b0;
      @(posedge SYS_CLK);
      apb(1'b0, trib_pkg::OFF_CTRL, 32'h0000_0000);
      chk("ctrl reset", rd, {23'h0, trib_pkg::CTRL_RST});
      apb(1'b0, 8'h18, 32'h0000_0000);
      chk("unmapped", perr, 1'b1);
      apb(1'b0, trib_pkg::OFF_PERR, 32'h0000_0000);
      chk("parity errors", rd, 32'h0000_0000);
      // group 7 of set three carries vt3
      apb(1'b1, trib_pkg::OFF_GRP2, 32'h0000_2000);
      mark(2'h3);
      repeat (2 * 2430) @(posedge SYS_CLK);
      apb(1'b1, trib_pkg::OFF_CTRL, 32'h0000_0031);
      apb(1'b0, trib_pkg::OFF_STAT, 32'h0000_0000);
      chk("one concat bit", rd[6:0], 7'h00);
      apb(1'b1, trib_pkg::OFF_CTRL, 32'h0000_0073);
      au4 = 1'b1;
      mixed = 1'b1;
      apb(1'b0, trib_pkg::OFF_STAT, 32'h0000_0000);
      chk("mixed modes", rd[6:0], 7'h1D);
      mark(2'h1);
      repeat (3 * 2430) @(posedge SYS_CLK);
      chk("shared phase", SET_MF_PHASE[5:2], {2{SET_MF_PHASE[1:0]}});
      results;
   end
endmodule : testbench
